// file: include/fic_pkg.sv
// shared constants and types of the fp/int conversion unit
package fic_pkg;
  // opcode field values
  localparam logic [6:0] OP_DBL_TO_INT_ROUNDED = 7'h08;
  localparam logic [6:0] OP_DBL_TO_INT_CHOP = 7'h01;
  localparam logic [6:0] OP_DBL_TO_SINGLE = 7'h09;
  localparam logic [6:0] OP_SIGNED_TO_DBL = 7'h39;
  localparam logic [6:0] OP_UNSIGNED_TO_DBL = 7'h3B;
  localparam logic [6:0] OP_SIGNED_TO_SINGLE = 7'h4A;
  localparam logic [6:0] OP_UNSIGNED_TO_SINGLE = 7'h49;

  // register map, byte offsets
  localparam int REG_ADDR_W = 8;
  localparam logic [7:0] ADDR_FP_ADD_CTRL = 8'h00;
  localparam logic [7:0] ADDR_FLAG_STATUS = 8'h04;
  localparam int CTRL_RMODE_LSB = 0;
  localparam logic [1:0] CTRL_RESET = 2'h0;

  // flag bit positions, in status register and per-op flag vector
  localparam int NUM_FLAGS = 7;
  localparam int FLG_BAD_OP = 0;
  localparam int FLG_ROUNDED = 1;
  localparam int FLG_OVERFLOW = 2;
  localparam int FLG_UNDERFLOW = 3;
  localparam int FLG_INF_RESULT = 4;
  localparam int FLG_SRC2_DENORM = 5;
  localparam int FLG_SRC2_NOTNUM = 6;
  localparam logic [6:0] STATUS_RESET = 7'h00;

  // rounding modes as held in the control register
  typedef enum logic [1:0] {RND_NEAREST, RND_ZERO, RND_POS_INF, RND_NEG_INF} fic_round_t;

  // number formats
  localparam logic [10:0] DBL_EXP_MAX = 11'h7FF;
  localparam int DBL_BIAS = 1023;
  localparam int SGL_BIAS = 127;
  localparam int SGL_EXP_TOP = 254;
  localparam logic [31:0] INT_SAT_POS = 32'h7FFF_FFFF;
  localparam logic [31:0] INT_SAT_NEG = 32'h8000_0000;
  localparam logic [31:0] DEFAULT_QUIET_NOTNUMBER = 32'h7FC0_0000;
  localparam logic [30:0] SGL_INF_MAG = 31'h7F80_0000;
  localparam logic [30:0] LARGEST_FINITE_VALUE = 31'h7F7F_FFFF;
  localparam logic [30:0] SMALLEST_FINITE_VALUE = 31'h0080_0000;

  // pipeline timing: delay slots to the low/single write and to the high word
  localparam int DELAY_SLOTS_SINGLE = 3;
  localparam int DELAY_SLOTS_DBL_HI = 4;
  localparam int STAGES = DELAY_SLOTS_SINGLE - 1;
endpackage : fic_pkg

// file: hdl/fic_conv_unit.sv
// fp/int conversion datapath with its control and flag registers
//
// Added by the designer: the register offsets and the strobed register port.
`timescale 1ns/1ps
module fic_conv_unit
  import fic_pkg::*;
(
  // clock, reset, enable
  input wire logic core_clk,
  input wire logic resetn,
  input wire logic clkEn,
  // issue and operand read
  input wire logic issueValid,
  input wire logic condPass,
  input wire logic [6:0] issueOp,
  input wire logic [4:0] issueDst,
  input wire logic [31:0] srcOnePort,
  input wire logic [31:0] srcTwoPort,
  // writeback
  output logic wrLoEn_r,
  output logic [4:0] wrLoIdx_r,
  output logic [31:0] wrLoData_r,
  output logic [NUM_FLAGS-1:0] wrFlags_r,
  output logic wrHiEn_r,
  output logic [4:0] wrHiIdx_r,
  output logic [31:0] wrHiData_r,
  // register port
  input wire logic [REG_ADDR_W-1:0] regAddr,
  input wire logic [31:0] regWrData,
  input wire logic regWr,
  input wire logic regRd,
  output logic [31:0] regRdData_r
);

  // leading zeros of a word, 32 for zero
  function automatic logic [5:0] lead_zeros(input logic [31:0] v);
    logic [5:0] n;
    n = 6'd32;
    for (int i = 0; i < 32; i++) begin
      if (v[i]) begin
        n = 6'(31 - i);
      end
    end
    return n;
  endfunction : lead_zeros

  // magnitude increment decision shared by all rounding paths
  function automatic logic round_up(input fic_round_t mode, input logic neg, input logic lsb,
                                    input logic rbit, input logic stk);
    logic up;
    up = 1'b0;
    unique case (mode)
      RND_NEAREST: up = rbit & (stk | lsb);
      RND_ZERO: up = 1'b0;
      RND_POS_INF: up = (rbit | stk) & ~neg;
      RND_NEG_INF: up = (rbit | stk) & neg;
    endcase
    return up;
  endfunction : round_up

  logic [1:0] ctrlMode_r;
  logic [NUM_FLAGS-1:0] status_r;
  logic [STAGES-1:0] pipeValid_r;
  logic [STAGES-1:0] pipeDbl_r;
  logic [4:0] pipeDst_r [STAGES];
  logic [31:0] pipeLo_r [STAGES];
  logic [31:0] pipeHi_r [STAGES];
  logic [NUM_FLAGS-1:0] pipeFlg_r [STAGES];
  logic hiHoldValid_r;
  logic [4:0] hiHoldIdx_r;
  logic [31:0] hiHoldData_r;
  // conversion intermediates
  logic [31:0] cvLo;
  logic [31:0] cvHi;
  logic [NUM_FLAGS-1:0] cvFlags;
  logic cvDouble;
  logic opKnown;
  fic_round_t mode;
  logic sgn;
  logic [10:0] dexp;
  logic [51:0] dman;
  logic signed [12:0] ex;
  logic signed [12:0] sexp;
  logic [6:0] shAmt;
  logic [87:0] wide;
  logic [87:0] shifted;
  logic rb;
  logic st;
  logic [32:0] imag;
  logic [30:0] spMag;
  logic awayMode;
  logic intNeg;
  logic [31:0] mag;
  logic [5:0] lz;
  logic [31:0] norm;
  logic accept;
  // operand fields; double source is split across both read ports
  always_comb begin
    sgn = srcTwoPort[31];
    dexp = srcTwoPort[30:20];
    dman = {srcTwoPort[19:0], srcOnePort};
    ex = $signed({2'b00, dexp}) - 13'(DBL_BIAS);
    sexp = ex + 13'(SGL_BIAS);
    if (issueOp == OP_DBL_TO_INT_CHOP) begin
      mode = RND_ZERO;
    end else begin
      mode = fic_round_t'(ctrlMode_r);
    end
    awayMode = (mode == RND_POS_INF && !sgn) || (mode == RND_NEG_INF && sgn);
    intNeg = srcTwoPort[31] && (issueOp == OP_SIGNED_TO_DBL || issueOp == OP_SIGNED_TO_SINGLE);
    mag = intNeg ? 32'(-srcTwoPort) : srcTwoPort;
    lz = lead_zeros(mag);
    norm = mag << lz;
  end

  // fixed-point alignment for the to-int path: binary point sits at bit 56
  always_comb begin
    shAmt = 7'(13'sd31 - ex);
    wide = {1'b1, dman, 35'h0};
    if (ex < -13'sd56) begin
      shifted = '0;
      st = 1'b1;
    end else begin
      shifted = wide >> shAmt;
      st = (|shifted[54:0]) | (|(wide & ~({88{1'b1}} << shAmt)));
    end
    rb = shifted[55];
    imag = {1'b0, shifted[87:56]} + 33'(round_up(mode, sgn, shifted[56], rb, st));
  end

  // result and flags of the issuing operation
  always_comb begin
    cvLo = 32'h0000_0000;
    cvHi = 32'h0000_0000;
    cvFlags = '0;
    cvDouble = 1'b0;
    opKnown = 1'b1;
    spMag = 31'h0000_0000;
    unique case (issueOp)
      OP_DBL_TO_INT_ROUNDED, OP_DBL_TO_INT_CHOP: begin
        if (dexp == DBL_EXP_MAX && dman != '0) begin
          cvLo = sgn ? INT_SAT_NEG : INT_SAT_POS;
          cvFlags[FLG_BAD_OP] = 1'b1;
        end else if (dexp == DBL_EXP_MAX || ex > 13'sd31 ||
                     imag > (sgn ? {1'b0, INT_SAT_NEG} : {1'b0, INT_SAT_POS})) begin
          cvLo = sgn ? INT_SAT_NEG : INT_SAT_POS;
          cvFlags[FLG_ROUNDED] = 1'b1;
          cvFlags[FLG_OVERFLOW] = 1'b1;
        end else if (dexp == '0) begin
          cvFlags[FLG_ROUNDED] = (dman != '0);
          cvFlags[FLG_SRC2_DENORM] = (dman != '0);
        end else begin
          cvLo = sgn ? 32'(-imag) : imag[31:0];
          cvFlags[FLG_ROUNDED] = rb | st;
        end
      end
      OP_DBL_TO_SINGLE: begin
        // rounding may carry into the exponent, caught as overflow below
        spMag = {sexp[7:0], dman[51:29]} + 31'(round_up(mode, sgn, dman[29], dman[28], |dman[27:0]));
        if (dexp == DBL_EXP_MAX && dman != '0) begin
          cvLo = DEFAULT_QUIET_NOTNUMBER;
          cvFlags[FLG_BAD_OP] = ~dman[51];
          cvFlags[FLG_SRC2_NOTNUM] = 1'b1;
        end else if (dexp == DBL_EXP_MAX) begin
          cvLo = {sgn, SGL_INF_MAG};
          cvFlags[FLG_INF_RESULT] = 1'b1;
        end else if (dexp == '0) begin
          cvLo = {sgn, 31'h0000_0000};
          cvFlags[FLG_ROUNDED] = (dman != '0);
          cvFlags[FLG_SRC2_DENORM] = (dman != '0);
        end else if (sexp > 13'(SGL_EXP_TOP) || spMag == SGL_INF_MAG) begin
          cvLo = {sgn, (mode == RND_NEAREST || awayMode) ? SGL_INF_MAG : LARGEST_FINITE_VALUE};
          cvFlags[FLG_ROUNDED] = 1'b1;
          cvFlags[FLG_OVERFLOW] = 1'b1;
        end else if (sexp < 13'sd1) begin
          cvLo = {sgn, awayMode ? SMALLEST_FINITE_VALUE : 31'h0000_0000};
          cvFlags[FLG_ROUNDED] = 1'b1;
          cvFlags[FLG_UNDERFLOW] = 1'b1;
        end else begin
          cvLo = {sgn, spMag};
          cvFlags[FLG_ROUNDED] = dman[28] | (|dman[27:0]);
        end
      end
      OP_SIGNED_TO_DBL, OP_UNSIGNED_TO_DBL: begin
        cvDouble = 1'b1;
        if (mag != '0) begin
          cvHi = {intNeg, 11'(DBL_BIAS + 31) - 11'(lz), norm[30:11]};
          cvLo = {norm[10:0], 21'h00_0000};
        end
        cvFlags = '0;
      end
      OP_SIGNED_TO_SINGLE, OP_UNSIGNED_TO_SINGLE: begin
        spMag = {8'(SGL_BIAS + 31) - 8'(lz), norm[30:8]} +
                31'(round_up(fic_round_t'(ctrlMode_r), intNeg, norm[8], norm[7], |norm[6:0]));
        if (mag != '0) begin
          cvLo = {intNeg, spMag};
        end
        cvFlags[FLG_ROUNDED] = norm[7] | (|norm[6:0]);
      end
      default: opKnown = 1'b0;
    endcase
  end

  assign accept = issueValid & condPass & opKnown;

  // pipeline control; all state holds while clkEn is low and resetn is high
  always_ff @(posedge core_clk) begin
    if (!resetn) begin
      pipeValid_r <= '0;
      pipeDbl_r <= '0;
    end else if (clkEn) begin
      pipeValid_r <= {pipeValid_r[STAGES-2:0], accept};
      pipeDbl_r <= {pipeDbl_r[STAGES-2:0], cvDouble};
    end
  end

  // pipeline data; no reset needed since valid bits qualify it
  always_ff @(posedge core_clk) begin
    if (clkEn) begin
      pipeDst_r[0] <= issueDst;
      pipeLo_r[0] <= cvLo;
      pipeHi_r[0] <= cvHi;
      pipeFlg_r[0] <= cvFlags;
      for (int i = 1; i < STAGES; i++) begin
        pipeDst_r[i] <= pipeDst_r[i-1];
        pipeLo_r[i] <= pipeLo_r[i-1];
        pipeHi_r[i] <= pipeHi_r[i-1];
        pipeFlg_r[i] <= pipeFlg_r[i-1];
      end
    end
  end

  // low word or single result, written three cycles after issue
  always_ff @(posedge core_clk) begin
    if (!resetn) begin
      wrLoEn_r <= 1'b0;
      wrLoIdx_r <= 5'h00;
      wrLoData_r <= 32'h0000_0000;
      wrFlags_r <= '0;
    end else if (clkEn) begin
      wrLoEn_r <= pipeValid_r[STAGES-1];
      wrLoIdx_r <= pipeDst_r[STAGES-1];
      wrLoData_r <= pipeLo_r[STAGES-1];
      wrFlags_r <= pipeValid_r[STAGES-1] ? pipeFlg_r[STAGES-1] : '0;
    end
  end

  // high word trails a cycle on its own port, clear of a later single result
  always_ff @(posedge core_clk) begin
    if (!resetn) begin
      hiHoldValid_r <= 1'b0;
      hiHoldIdx_r <= 5'h00;
      hiHoldData_r <= 32'h0000_0000;
      wrHiEn_r <= 1'b0;
      wrHiIdx_r <= 5'h00;
      wrHiData_r <= 32'h0000_0000;
    end else if (clkEn) begin
      hiHoldValid_r <= pipeValid_r[STAGES-1] & pipeDbl_r[STAGES-1];
      hiHoldIdx_r <= {pipeDst_r[STAGES-1][4:1], 1'b1};
      hiHoldData_r <= pipeHi_r[STAGES-1];
      wrHiEn_r <= hiHoldValid_r;
      wrHiIdx_r <= hiHoldIdx_r;
      wrHiData_r <= hiHoldData_r;
    end
  end

  // rounding mode control register
  always_ff @(posedge core_clk) begin
    if (!resetn) begin
      ctrlMode_r <= CTRL_RESET;
    end else if (clkEn && regWr && regAddr == ADDR_FP_ADD_CTRL) begin
      ctrlMode_r <= regWrData[CTRL_RMODE_LSB +: 2];
    end
  end

  // sticky flags, write one to clear; a new event beats its clear
  always_ff @(posedge core_clk) begin
    if (!resetn) begin
      status_r <= STATUS_RESET;
    end else if (clkEn) begin
      status_r <= (status_r & ~((regWr && regAddr == ADDR_FLAG_STATUS) ? regWrData[NUM_FLAGS-1:0] : '0))
                  | (pipeValid_r[STAGES-1] ? pipeFlg_r[STAGES-1] : '0);
    end
  end

  // read data stands only in the cycle after the strobe
  always_ff @(posedge core_clk) begin
    if (!resetn) begin
      regRdData_r <= 32'h0000_0000;
    end else if (clkEn) begin
      regRdData_r <= 32'h0000_0000;
      if (regRd && regAddr == ADDR_FP_ADD_CTRL) begin
        regRdData_r <= {30'h0000_0000, ctrlMode_r};
      end else if (regRd && regAddr == ADDR_FLAG_STATUS) begin
        regRdData_r <= {25'h000_0000, status_r};
      end
    end
  end

endmodule : fic_conv_unit

// file: sim/fic_conv_unit_chk.sv
// concurrent checks on the conversion unit ports
`timescale 1ns/1ps
module fic_conv_unit_chk
  import fic_pkg::*;
(
  // clock and reset
  input wire logic core_clk,
  input wire logic resetn,
  input wire logic clkEn,
  // issue
  input wire logic issueValid,
  input wire logic condPass,
  input wire logic [6:0] issueOp,
  input wire logic [4:0] issueDst,
  input wire logic [31:0] srcOnePort,
  input wire logic [31:0] srcTwoPort,
  // writeback
  input wire logic wrLoEn_r,
  input wire logic [4:0] wrLoIdx_r,
  input wire logic [31:0] wrLoData_r,
  input wire logic [NUM_FLAGS-1:0] wrFlags_r,
  input wire logic wrHiEn_r,
  input wire logic [4:0] wrHiIdx_r,
  input wire logic [31:0] wrHiData_r,
  // register port
  input wire logic [REG_ADDR_W-1:0] regAddr,
  input wire logic [31:0] regWrData,
  input wire logic regWr,
  input wire logic regRd,
  input wire logic [31:0] regRdData_r
);
  default clocking @(posedge core_clk); endclocking
  default disable iff (!resetn);

  // issue decode helpers; counts assume clkEn held high
  wire logic taken = issueValid && condPass && clkEn;
  wire logic toDbl = issueOp == OP_SIGNED_TO_DBL || issueOp == OP_UNSIGNED_TO_DBL;
  wire logic toSgl = issueOp == OP_SIGNED_TO_SINGLE || issueOp == OP_UNSIGNED_TO_SINGLE;
  wire logic known = toDbl || toSgl || issueOp == OP_DBL_TO_SINGLE || issueOp == OP_DBL_TO_INT_ROUNDED
    || issueOp == OP_DBL_TO_INT_CHOP;

  AST_LO_LATENCY: assert property (taken && known |-> ##3 wrLoEn_r && wrLoIdx_r == $past(issueDst, 3))
    else $error("low write not three cycles after issue");
  AST_NO_STRAY: assert property (wrLoEn_r |-> $past(taken, 3))
    else $error("write without a passing issue");
  AST_HI_LATENCY: assert property (taken && toDbl |-> ##3 wrLoEn_r ##1 wrHiEn_r)
    else $error("high word not a cycle after low word");
  AST_HI_PAIR: assert property (wrHiEn_r |-> $past(wrLoEn_r) && wrHiIdx_r == ($past(wrLoIdx_r) | 5'h01))
    else $error("high word not paired with low word");
  AST_DBL_NOFLAG: assert property (taken && toDbl |-> ##3 wrFlags_r == 7'h00)
    else $error("int to double raised a flag");
  AST_SGL_FLAGS: assert property (taken && toSgl |-> ##3 (wrFlags_r & 7'h7D) == 7'h00)
    else $error("int to single raised a flag other than rounded");
  AST_INT_SAT: assert property (wrLoEn_r && wrFlags_r[FLG_OVERFLOW] && ($past(issueOp, 3) == OP_DBL_TO_INT_CHOP
    || $past(issueOp, 3) == OP_DBL_TO_INT_ROUNDED) |-> wrFlags_r[FLG_ROUNDED]
    && (wrLoData_r == INT_SAT_POS || wrLoData_r == INT_SAT_NEG))
    else $error("to-int overflow not saturated");
  AST_DEFAULT_QUIET_NOTNUMBER: assert property (wrLoEn_r && wrFlags_r[FLG_SRC2_NOTNUM] && $past(issueOp, 3) == OP_DBL_TO_SINGLE
    |-> wrLoData_r == DEFAULT_QUIET_NOTNUMBER)
    else $error("nan source did not give the quiet nan");
  AST_INF_OUT: assert property (wrLoEn_r && wrFlags_r[FLG_INF_RESULT] && $past(issueOp, 3) == OP_DBL_TO_SINGLE
    |-> wrLoData_r[30:0] == SGL_INF_MAG)
    else $error("infinite result not an infinity");
endmodule : fic_conv_unit_chk

bind fic_conv_unit fic_conv_unit_chk chk_u (.core_clk, .resetn, .clkEn, .issueValid, .condPass, .issueOp,
  .issueDst, .srcOnePort, .srcTwoPort, .wrLoEn_r, .wrLoIdx_r, .wrLoData_r, .wrFlags_r, .wrHiEn_r, .wrHiIdx_r,
  .wrHiData_r, .regAddr, .regWrData, .regWr, .regRd, .regRdData_r);

// file: sim/fic_rf_model.sv
// register file model catching the unit's writeback
`timescale 1ns/1ps
module fic_rf_model
  import fic_pkg::*;
(
  // clock
  input wire logic core_clk,
  // writeback ports
  input wire logic wrLoEn_r,
  input wire logic [4:0] wrLoIdx_r,
  input wire logic [31:0] wrLoData_r,
  input wire logic [NUM_FLAGS-1:0] wrFlags_r,
  input wire logic wrHiEn_r,
  input wire logic [4:0] wrHiIdx_r,
  input wire logic [31:0] wrHiData_r
);
  logic [31:0] regs [32];
  logic [NUM_FLAGS-1:0] lastFlags;

  // both ports may land in one cycle, so they write independently
  always_ff @(posedge core_clk) begin
    if (wrLoEn_r) begin
      regs[wrLoIdx_r] <= wrLoData_r;
      lastFlags <= wrFlags_r;
    end
    if (wrHiEn_r) begin
      regs[wrHiIdx_r] <= wrHiData_r;
    end
  end
endmodule : fic_rf_model

// file: sim/fic_conv_unit_test.sv
// directed testbench for the conversion unit
`timescale 1ns/1ps
module fic_conv_unit_test
  import fic_pkg::*;
;
  logic core_clk = 1'b0;
  logic resetn = 1'b0;
  logic issueValid = 1'b0;
  logic condPass = 1'b0;
  logic [6:0] issueOp = 7'h00;
  logic [4:0] issueDst = 5'h00;
  logic [31:0] srcOnePort = 32'h0000_0000;
  logic [31:0] srcTwoPort = 32'h0000_0000;
  logic [7:0] regAddr = 8'h00;
  logic [31:0] regWrData = 32'h0000_0000;
  logic regWr = 1'b0;
  logic regRd = 1'b0;
  logic wrLoEn_r, wrHiEn_r;
  logic [4:0] wrLoIdx_r, wrHiIdx_r;
  logic [31:0] wrLoData_r, wrHiData_r, regRdData_r, rd;
  logic [NUM_FLAGS-1:0] wrFlags_r;
  int errors = 0;
  int numChecks = 0;
  int cycles = 0;
  // expected results per rounding mode: nearest, zero, +inf, -inf
  logic [31:0] ovPos [4] = '{32'h7F80_0000, 32'h7F7F_FFFF, 32'h7F80_0000, 32'h7F7F_FFFF};
  logic [31:0] ovNeg [4] = '{32'hFF80_0000, 32'hFF7F_FFFF, 32'hFF7F_FFFF, 32'hFF80_0000};
  logic [31:0] unPos [4] = '{32'h0000_0000, 32'h0000_0000, 32'h0080_0000, 32'h0000_0000};
  logic [31:0] unNeg [4] = '{32'h8000_0000, 32'h8000_0000, 32'h8000_0000, 32'h8080_0000};
  logic [31:0] rndNeg [4] = '{32'hFFFF_FFF7, 32'hFFFF_FFF8, 32'hFFFF_FFF8, 32'hFFFF_FFF7};

  // clock enable tied high: freezing is not exercised here
  fic_conv_unit dut_u (.core_clk, .resetn, .clkEn(1'b1), .issueValid, .condPass, .issueOp, .issueDst,
    .srcOnePort, .srcTwoPort, .wrLoEn_r, .wrLoIdx_r, .wrLoData_r, .wrFlags_r, .wrHiEn_r, .wrHiIdx_r,
    .wrHiData_r, .regAddr, .regWrData, .regWr, .regRd, .regRdData_r);
  fic_rf_model rf_u (.core_clk, .wrLoEn_r, .wrLoIdx_r, .wrLoData_r, .wrFlags_r, .wrHiEn_r, .wrHiIdx_r,
    .wrHiData_r);

  always #2.5 core_clk = ~core_clk;

  task automatic finish_test();
    $display("checks %0d errors %0d", numChecks, errors);
    if (errors == 0 && numChecks > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask : finish_test

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    numChecks++;
    if (got !== exp) begin
      errors++;
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk

  // bus tasks: entered just after a rising edge, leave one idle cycle
  task automatic wrReg(input logic [7:0] a, input logic [31:0] d);
    regAddr <= a;
    regWrData <= d;
    regWr <= 1'b1;
    @(posedge core_clk);
    regWr <= 1'b0;
    @(posedge core_clk);
  endtask : wrReg

  task automatic rdReg(input logic [7:0] a, output logic [31:0] d);
    regAddr <= a;
    regRd <= 1'b1;
    @(posedge core_clk);
    regRd <= 1'b0;
    #1 d = regRdData_r;
    @(posedge core_clk);
  endtask : rdReg

  // leaves issueValid high so issues can run back to back
  task automatic iss(input logic [6:0] op, input logic [31:0] hi, input logic [31:0] lo, input logic [4:0] dst,
    input logic cp);
    issueValid <= 1'b1;
    condPass <= cp;
    issueOp <= op;
    issueDst <= dst;
    srcTwoPort <= hi;
    srcOnePort <= lo;
    @(posedge core_clk);
  endtask : iss

  // one op from a clean status, then result, flags and sticky status
  task automatic run(input logic [6:0] op, input logic [31:0] hi, input logic [31:0] lo, input logic [4:0] dst,
    input logic [31:0] expLo, input logic [6:0] expFl);
    logic [31:0] st;
    wrReg(ADDR_FLAG_STATUS, 32'h0000_007F);
    iss(op, hi, lo, dst, 1'b1);
    issueValid <= 1'b0;
    repeat (5) @(posedge core_clk);
    chk(rf_u.regs[dst], expLo);
    chk({25'h0, rf_u.lastFlags}, {25'h0, expFl});
    rdReg(ADDR_FLAG_STATUS, st);
    chk(st, {25'h0, expFl});
  endtask : run

  // a hang ends the run as a failure
  always @(posedge core_clk) begin
    cycles++;
    if (cycles == 5000) begin
      errors++;
      finish_test();
    end
  end

  initial begin
    repeat (3) @(posedge core_clk);
    resetn <= 1'b1;
    @(posedge core_clk);
    run(OP_DBL_TO_INT_ROUNDED, 32'h4021_3333, 32'h3333_3333, 5'h02, 32'h0000_0009, 7'h02);
    run(OP_DBL_TO_INT_ROUNDED, 32'h7FF0_0000, 32'h0000_0000, 5'h02, 32'h7FFF_FFFF, 7'h06);
    run(OP_DBL_TO_INT_CHOP, 32'hC1F0_0000, 32'h0000_0000, 5'h03, 32'h8000_0000, 7'h06);
    run(OP_DBL_TO_INT_CHOP, 32'h0000_0001, 32'h0000_0000, 5'h04, 32'h0000_0000, 7'h22);
    run(OP_DBL_TO_INT_ROUNDED, 32'hFFF8_0000, 32'h0000_0000, 5'h05, 32'h8000_0000, 7'h01);
    run(OP_DBL_TO_SINGLE, 32'h4021_3333, 32'h3333_3333, 5'h06, 32'h4109_999A, 7'h02);
    run(OP_DBL_TO_SINGLE, 32'h7FF0_0000, 32'h0000_0001, 5'h06, DEFAULT_QUIET_NOTNUMBER, 7'h41);
    run(OP_DBL_TO_SINGLE, 32'h7FF8_0000, 32'h0000_0000, 5'h06, DEFAULT_QUIET_NOTNUMBER, 7'h40);
    run(OP_DBL_TO_SINGLE, 32'h8000_0000, 32'h0000_0001, 5'h06, 32'h8000_0000, 7'h22);
    run(OP_DBL_TO_SINGLE, 32'hFFF0_0000, 32'h0000_0000, 5'h06, 32'hFF80_0000, 7'h10);
    run(OP_SIGNED_TO_SINGLE, 32'h1965_1127, 32'h0000_0000, 5'h07, 32'h4DCB_2889, 7'h02);
    run(OP_SIGNED_TO_SINGLE, 32'h8000_0000, 32'h0000_0000, 5'h07, 32'hCF00_0000, 7'h00);
    run(OP_UNSIGNED_TO_SINGLE, 32'h8000_0000, 32'h0000_0000, 5'h07, 32'h4F00_0000, 7'h00);
    run(OP_SIGNED_TO_DBL, 32'hFFFF_FFFF, 32'h0000_0000, 5'h08, 32'h0000_0000, 7'h00);
    chk(rf_u.regs[9], 32'hBFF0_0000);
    run(OP_UNSIGNED_TO_DBL, 32'hFFFF_FFFF, 32'h0000_0000, 5'h0A, 32'hFFE0_0000, 7'h00);
    chk(rf_u.regs[11], 32'h41EF_FFFF);
    // adjacent issues, double then single
    iss(OP_SIGNED_TO_DBL, 32'h0000_0001, 32'h0000_0000, 5'h0C, 1'b1);
    iss(OP_UNSIGNED_TO_SINGLE, 32'h0000_0002, 32'h0000_0000, 5'h0E, 1'b1);
    issueValid <= 1'b0;
    repeat (5) @(posedge core_clk);
    chk(rf_u.regs[13], 32'h3FF0_0000);
    chk(rf_u.regs[14], 32'h4000_0000);
    // failed condition, then an unknown opcode: destination and status stay put
    iss(OP_DBL_TO_SINGLE, 32'hFFF0_0000, 32'h0000_0000, 5'h0E, 1'b0);
    iss(7'h7F, 32'hFFF0_0000, 32'h0000_0000, 5'h0E, 1'b1);
    issueValid <= 1'b0;
    repeat (5) @(posedge core_clk);
    chk(rf_u.regs[14], 32'h4000_0000);
    rdReg(ADDR_FLAG_STATUS, rd);
    chk(rd, 32'h0000_0000);
    for (int m = 0; m < 4; m++) begin
      wrReg(ADDR_FP_ADD_CTRL, 32'(m));
      rdReg(ADDR_FP_ADD_CTRL, rd);
      chk(rd, 32'(m));
      run(OP_DBL_TO_SINGLE, 32'h7FE0_0000, 32'h0000_0000, 5'h10, ovPos[m], 7'h06);
      run(OP_DBL_TO_SINGLE, 32'hFFE0_0000, 32'h0000_0000, 5'h10, ovNeg[m], 7'h06);
      run(OP_DBL_TO_SINGLE, 32'h0170_0000, 32'h0000_0000, 5'h10, unPos[m], 7'h0A);
      run(OP_DBL_TO_SINGLE, 32'h8170_0000, 32'h0000_0000, 5'h10, unNeg[m], 7'h0A);
      run(OP_DBL_TO_INT_CHOP, 32'hC021_3333, 32'h3333_3333, 5'h11, 32'hFFFF_FFF8, 7'h02);
      run(OP_DBL_TO_INT_ROUNDED, 32'hC021_3333, 32'h3333_3333, 5'h11, rndNeg[m], 7'h02);
    end
    // unmapped address reads as zero
    rdReg(8'h10, rd);
    chk(rd, 32'h0000_0000);
    finish_test();
  end
endmodule : fic_conv_unit_test
